//--- hdl/urx_block.sv
// receive level counter, trigger, flow characters and their status
`timescale 1ns/1ps
module urx_block (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic RX_PUSH,
  input wire logic RX_POP,
  input wire logic TX_SENT_RESUME,
  input wire logic TX_SENT_STOP,
  input wire logic RX_GOT_RESUME,
  input wire logic RX_GOT_STOP,
  input wire logic [3:0] MODEM_IN,
  input wire logic [7:0] LINE_STATUS_IN,
  output logic [7:0] STOP_CHAR_FIRST,
  output logic [7:0] STOP_CHAR_SECOND,
  output logic [7:0] RESUME_CHAR_FIRST,
  output logic [7:0] RESUME_CHAR_SECOND,
  output logic [3:0] FLOW_SELECT,
  output logic [7:0] DIVISOR,
  output logic [7:0] DIVISOR_HIGH,
  output logic [7:0] DIVISOR_FRAC,
  output logic SER_TX,
  output logic IR_TX,
  output logic RTS_N,
  output logic DTR_N,
  output logic MEM_CLK,
  output logic MEM_SEL,
  output logic MEM_DATA,
  output logic IRQ
);
  logic rst_meta_r;
  logic rst_sync_r;
  logic rst_n;
  logic [3:0] modem_meta_r;
  logic [3:0] modem_sync_r;
  logic [3:0] modem_prev_r;
  logic [3:0] modem_chg_r;
  logic [7:0] rx_count_r;
  logic [7:0] rx_count_nxt;
  logic [7:0] rx_trig_r;
  logic [7:0] stop1_r;
  logic [7:0] stop2_r;
  logic [7:0] resume1_r;
  logic [7:0] resume2_r;
  logic [3:0] flow_sel_r;
  logic [3:0] flow_stat_r;
  logic [7:0] line_stat_r;
  logic [7:0] int_stat_r;
  logic [7:0] scratch_r;
  logic [7:0] div_low_r;
  logic [7:0] div_high_r;
  logic [7:0] div_frac_r;
  logic [urx_pkg::IRQ_W-1:0] irq_stat_r;
  logic [urx_pkg::IRQ_W-1:0] irq_mask_r;
  logic [urx_pkg::IRQ_W-1:0] irq_evt;
  logic ack_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic wr_go;
  logic rd_go;
  logic flow_off;
  logic trig_hit;
  logic [7:0] wb;
  logic [1:0] modem_warm_r;
  logic [3:0] modem_delta;
  logic [3:0] flow_keep;
  logic rd_flow_hit;
  logic rd_modem_hit;

  // reset release through two flip-flops
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rst_n = rst_sync_r;

  // bus: every access answered one cycle after it appears
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_r;
  assign wr_go = AVS_WRITE & ack_r;
  assign rd_go = AVS_READ & ack_r;
  assign wb = AVS_WRITEDATA[7:0];
  assign rd_flow_hit = rd_go && (AVS_ADDRESS == urx_pkg::IDX_FLOW_STAT);
  assign rd_modem_hit = rd_go && (AVS_ADDRESS == urx_pkg::IDX_MODEM_STAT);

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (AVS_READ | AVS_WRITE) & ~ack_r;
    end
  end

  // modem inputs synchronised
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      modem_meta_r <= 4'h0;
      modem_sync_r <= 4'h0;
    end else begin
      modem_meta_r <= MODEM_IN;
      modem_sync_r <= modem_meta_r;
    end
  end

  // change history trusted only once synchroniser and history hold real levels
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      modem_warm_r <= 2'h0;
    end else if (modem_warm_r != 2'h3) begin
      modem_warm_r <= modem_warm_r + 2'h1;
    end
  end
  assign modem_delta = (modem_warm_r == 2'h3) ? (modem_sync_r ^ modem_prev_r) : 4'h0;

  // modem change bits, cleared by reset and by read, a new change wins
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      modem_prev_r <= 4'h0;
      modem_chg_r <= 4'h0;
    end else begin
      modem_prev_r <= modem_sync_r;
      if (rd_modem_hit) begin
        modem_chg_r <= (modem_chg_r & ~rdata_r[3:0]) | modem_delta;
      end else begin
        modem_chg_r <= modem_chg_r | modem_delta;
      end
    end
  end

  // receive fifo level counter
  always_comb begin
    rx_count_nxt = rx_count_r;
    if (RX_PUSH && !RX_POP && rx_count_r < urx_pkg::FIFO_DEPTH) begin
      rx_count_nxt = rx_count_r + 8'h01;
    end else if (RX_POP && !RX_PUSH && rx_count_r != 8'h00) begin
      rx_count_nxt = rx_count_r - 8'h01;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rx_count_r <= urx_pkg::RST_ZERO;
    end else begin
      rx_count_r <= rx_count_nxt;
    end
  end

  // rises to trigger level
  assign trig_hit = (rx_count_nxt == rx_trig_r) && (rx_count_nxt > rx_count_r);

  // receive trigger level, values above the fifo depth clamp to it
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rx_trig_r <= urx_pkg::RST_ZERO;
    end else if (wr_go && AVS_ADDRESS == urx_pkg::IDX_RX_TRIG) begin
      rx_trig_r <= (wb > urx_pkg::FIFO_DEPTH) ? urx_pkg::FIFO_DEPTH : wb;
    end
  end

  // stop and resume characters for software flow control
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      stop1_r <= urx_pkg::RST_ZERO;
      stop2_r <= urx_pkg::RST_ZERO;
      resume1_r <= urx_pkg::RST_ZERO;
      resume2_r <= urx_pkg::RST_ZERO;
    end else if (wr_go) begin
      unique case (AVS_ADDRESS)
        urx_pkg::IDX_STOP1: stop1_r <= wb;
        urx_pkg::IDX_STOP2: stop2_r <= wb;
        urx_pkg::IDX_RESUME1: resume1_r <= wb;
        urx_pkg::IDX_RESUME2: resume2_r <= wb;
        default: begin
        end
      endcase
    end
  end

  // flow select, all zero turns software flow control off
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      flow_sel_r <= 4'h0;
    end else if (wr_go && AVS_ADDRESS == urx_pkg::IDX_FLOW_SEL) begin
      flow_sel_r <= wb[3:0];
    end
  end

  // scratch register
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      scratch_r <= urx_pkg::RST_SCRATCH;
    end else if (wr_go && AVS_ADDRESS == urx_pkg::IDX_SCRATCH) begin
      scratch_r <= wb;
    end
  end

  // divisor bytes
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      div_low_r <= urx_pkg::RST_DIV_LOW;
      div_high_r <= urx_pkg::RST_ZERO;
      div_frac_r <= urx_pkg::RST_ZERO;
    end else if (wr_go) begin
      unique case (AVS_ADDRESS)
        urx_pkg::IDX_DIV_LOW: div_low_r <= wb;
        urx_pkg::IDX_DIV_HIGH: div_high_r <= wb;
        urx_pkg::IDX_DIV_FRAC: div_frac_r <= wb;
        default: begin
        end
      endcase
    end
  end

  // interrupt mask
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_r <= '0;
    end else if (wr_go && AVS_ADDRESS == urx_pkg::IDX_IRQ_MASK) begin
      irq_mask_r <= wb[urx_pkg::IRQ_W-1:0];
    end
  end

  // flow character status
  assign flow_off = (flow_sel_r == 4'h0);
  // a read clears only what it returned, so an event after capture survives
  assign flow_keep = flow_stat_r & ~rdata_r[3:0];

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      flow_stat_r <= 4'h0;
    end else if (flow_off) begin
      flow_stat_r <= 4'h0;
    end else begin
      if (TX_SENT_RESUME) begin
        flow_stat_r[urx_pkg::FS_TX_RESUME] <= 1'b1;
        flow_stat_r[urx_pkg::FS_TX_STOP] <= 1'b0;
      end else if (TX_SENT_STOP) begin
        flow_stat_r[urx_pkg::FS_TX_STOP] <= 1'b1;
        flow_stat_r[urx_pkg::FS_TX_RESUME] <= 1'b0;
      end else if (rd_flow_hit) begin
        flow_stat_r[urx_pkg::FS_TX_RESUME] <= flow_keep[urx_pkg::FS_TX_RESUME];
        flow_stat_r[urx_pkg::FS_TX_STOP] <= flow_keep[urx_pkg::FS_TX_STOP];
      end
      if (RX_GOT_RESUME) begin
        flow_stat_r[urx_pkg::FS_RX_RESUME] <= 1'b1;
        flow_stat_r[urx_pkg::FS_RX_STOP] <= 1'b0;
      end else if (RX_GOT_STOP) begin
        flow_stat_r[urx_pkg::FS_RX_STOP] <= 1'b1;
        flow_stat_r[urx_pkg::FS_RX_RESUME] <= 1'b0;
      end else if (rd_flow_hit) begin
        flow_stat_r[urx_pkg::FS_RX_RESUME] <= flow_keep[urx_pkg::FS_RX_RESUME];
        flow_stat_r[urx_pkg::FS_RX_STOP] <= flow_keep[urx_pkg::FS_RX_STOP];
      end
    end
  end

  // line status mirror, one cycle behind its input
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      line_stat_r <= urx_pkg::RST_LINE_STAT;
    end else begin
      line_stat_r <= LINE_STATUS_IN;
    end
  end

  // interrupt status, bit 0 high while no interrupt is pending
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      int_stat_r <= urx_pkg::RST_INT_STAT;
    end else begin
      int_stat_r <= {7'h00, ~IRQ};
    end
  end

  // sticky interrupt status, write one to clear, set wins
  assign irq_evt[urx_pkg::IRQ_RX_TRIG] = trig_hit;
  assign irq_evt[urx_pkg::IRQ_FLOW_RX] = ~flow_off & (RX_GOT_RESUME | RX_GOT_STOP);
  assign irq_evt[urx_pkg::IRQ_FLOW_TX] = ~flow_off & (TX_SENT_RESUME | TX_SENT_STOP);

  genvar gi;
  generate
    for (gi = 0; gi < urx_pkg::IRQ_W; gi = gi + 1) begin : g_irq
      always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
          irq_stat_r[gi] <= 1'b0;
        end else if (irq_evt[gi]) begin
          irq_stat_r[gi] <= 1'b1;
        end else if (wr_go && AVS_ADDRESS == urx_pkg::IDX_IRQ_STAT && wb[gi]) begin
          irq_stat_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign IRQ = |(irq_stat_r & irq_mask_r);

  // read mux, write-only registers read zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (AVS_ADDRESS)
      urx_pkg::IDX_RX_COUNT: rdata_nxt[7:0] = rx_count_r;
      urx_pkg::IDX_FLOW_STAT: rdata_nxt[7:0] = {4'h0, flow_stat_r};
      urx_pkg::IDX_FLOW_SEL: rdata_nxt[3:0] = flow_sel_r;
      urx_pkg::IDX_IRQ_STAT: rdata_nxt[urx_pkg::IRQ_W-1:0] = irq_stat_r;
      urx_pkg::IDX_IRQ_MASK: rdata_nxt[urx_pkg::IRQ_W-1:0] = irq_mask_r;
      urx_pkg::IDX_LINE_STAT: rdata_nxt[7:0] = line_stat_r;
      urx_pkg::IDX_INT_STAT: rdata_nxt[7:0] = int_stat_r;
      urx_pkg::IDX_SCRATCH: rdata_nxt[7:0] = scratch_r;
      urx_pkg::IDX_DIV_LOW: rdata_nxt[7:0] = div_low_r;
      urx_pkg::IDX_DIV_HIGH: rdata_nxt[7:0] = div_high_r;
      urx_pkg::IDX_DIV_FRAC: rdata_nxt[7:0] = div_frac_r;
      urx_pkg::IDX_MODEM_STAT: rdata_nxt[7:0] = {modem_sync_r, modem_chg_r};
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (AVS_READ && !ack_r) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign AVS_READDATA = rdata_r;
  assign STOP_CHAR_FIRST = stop1_r;
  assign STOP_CHAR_SECOND = stop2_r;
  assign RESUME_CHAR_FIRST = resume1_r;
  assign RESUME_CHAR_SECOND = resume2_r;
  assign FLOW_SELECT = flow_sel_r;
  assign DIVISOR = div_low_r;
  assign DIVISOR_HIGH = div_high_r;
  assign DIVISOR_FRAC = div_frac_r;

  // serial pins idle state after reset
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      SER_TX <= 1'b1;
      RTS_N <= 1'b1;
      DTR_N <= 1'b1;
      IR_TX <= 1'b0;
      MEM_CLK <= 1'b0;
      MEM_SEL <= 1'b0;
      MEM_DATA <= 1'b0;
    end else begin
      SER_TX <= 1'b1;
      RTS_N <= 1'b1;
      DTR_N <= 1'b1;
      IR_TX <= 1'b0;
      MEM_CLK <= 1'b0;
      MEM_SEL <= 1'b0;
      MEM_DATA <= 1'b0;
    end
  end
endmodule

//--- hdl/urx_pkg.sv
// shared constants for the receive level and flow character block
package urx_pkg;
  localparam int ADDR_W = 6;
  // word indices on the bus, byte address is four times the index
  localparam logic [5:0] IDX_RX_COUNT = 6'h00;
  localparam logic [5:0] IDX_RX_TRIG = 6'h01;
  localparam logic [5:0] IDX_STOP1 = 6'h02;
  localparam logic [5:0] IDX_STOP2 = 6'h03;
  localparam logic [5:0] IDX_RESUME1 = 6'h04;
  localparam logic [5:0] IDX_RESUME2 = 6'h05;
  localparam logic [5:0] IDX_FLOW_STAT = 6'h06;
  localparam logic [5:0] IDX_FLOW_SEL = 6'h07;
  localparam logic [5:0] IDX_IRQ_STAT = 6'h08;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h09;
  localparam logic [5:0] IDX_LINE_STAT = 6'h0A;
  localparam logic [5:0] IDX_INT_STAT = 6'h0B;
  localparam logic [5:0] IDX_SCRATCH = 6'h0C;
  localparam logic [5:0] IDX_DIV_LOW = 6'h0D;
  localparam logic [5:0] IDX_DIV_HIGH = 6'h0E;
  localparam logic [5:0] IDX_DIV_FRAC = 6'h0F;
  localparam logic [5:0] IDX_MODEM_STAT = 6'h10;
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_LINE_STAT = 8'h60;
  localparam logic [7:0] RST_INT_STAT = 8'h01;
  localparam logic [7:0] RST_SCRATCH = 8'hFF;
  localparam logic [7:0] RST_DIV_LOW = 8'h01;
  // counts
  localparam logic [7:0] FIFO_DEPTH = 8'h40;
  // flow status bit positions
  localparam int FS_TX_RESUME = 3;
  localparam int FS_TX_STOP = 2;
  localparam int FS_RX_RESUME = 1;
  localparam int FS_RX_STOP = 0;
  // interrupt status bit positions
  localparam int IRQ_W = 3;
  localparam int IRQ_RX_TRIG = 0;
  localparam int IRQ_FLOW_RX = 1;
  localparam int IRQ_FLOW_TX = 2;
endpackage

//--- testbench/urx_checker.sv
// concurrent checks on bus answers, register writes and reset outputs
`timescale 1ns/1ps
module urx_checker (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic [7:0] STOP_CHAR_FIRST,
  input wire logic [3:0] FLOW_SELECT,
  input wire logic [7:0] DIVISOR,
  input wire logic [7:0] DIVISOR_HIGH,
  input wire logic [7:0] DIVISOR_FRAC,
  input wire logic SER_TX,
  input wire logic IR_TX,
  input wire logic RTS_N,
  input wire logic DTR_N,
  input wire logic MEM_CLK,
  input wire logic MEM_SEL,
  input wire logic MEM_DATA
);
  logic wr_ok, rd_ok;
  logic [7:0] wd;
  assign wr_ok = AVS_WRITE && !AVS_WAITREQUEST;
  assign rd_ok = AVS_READ && !AVS_WAITREQUEST;
  assign wd = AVS_WRITEDATA[7:0];
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  reset_pins_a: assert property ($rose(RSTN) |-> SER_TX && RTS_N && DTR_N
    && !(IR_TX || MEM_CLK || MEM_SEL || MEM_DATA)) else $error("reset pin level wrong");
  reset_regs_a: assert property ($rose(RSTN) |-> DIVISOR == 8'h01 && DIVISOR_HIGH == 8'h00
    && DIVISOR_FRAC == 8'h00 && STOP_CHAR_FIRST == 8'h00 && FLOW_SELECT == 4'h0)
    else $error("reset register value wrong");
  stop_write_a: assert property (wr_ok && AVS_ADDRESS == 6'h02
    |=> STOP_CHAR_FIRST == $past(wd)) else $error("stop char not written");
  sel_write_a: assert property (wr_ok && AVS_ADDRESS == 6'h07
    |=> {4'h0, FLOW_SELECT} == ($past(wd) & 8'h0F)) else $error("flow select not written");
  flow_upper_a: assert property (rd_ok && AVS_ADDRESS == 6'h06
    |-> AVS_READDATA[31:4] == 28'h0) else $error("flow status upper bits set");
  flow_off_a: assert property (rd_ok && AVS_ADDRESS == 6'h06 && FLOW_SELECT == 4'h0
    |-> AVS_READDATA == 32'h0) else $error("flow status not zero while disabled");
  wo_read_a: assert property (rd_ok && AVS_ADDRESS inside {[6'h01:6'h05]}
    |-> AVS_READDATA == 32'h0) else $error("write-only register read back");
  count_max_a: assert property (rd_ok && AVS_ADDRESS == 6'h00
    |-> AVS_READDATA <= 32'h40) else $error("rx count above depth");
endmodule
bind urx_block urx_checker urx_checker_inst (.*);

//--- testbench/urx_peer.sv
// far-side model that emits bursts of line event pulses
`timescale 1ns/1ps
module urx_peer (
  input wire logic CLK,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [5:0] kind,
  input wire logic [6:0] reps,
  output logic [5:0] ev,
  output logic busy
);
  logic [6:0] left_r;
  logic [5:0] kind_r;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      left_r <= 7'h00;
      kind_r <= 6'h00;
    end else if (start) begin
      left_r <= reps;
      kind_r <= kind;
    end else if (left_r != 7'h00) begin
      left_r <= left_r - 7'h01;
    end
  end
  assign busy = left_r != 7'h00;
  assign ev = busy ? kind_r : 6'h00;
endmodule

//--- testbench/testbench.sv
// self-checking bench for the receive level and flow character block
`timescale 1ns/1ps
module testbench;
  logic CLK, RSTN, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, IRQ, start, busy;
  logic RX_PUSH, RX_POP, TX_SENT_RESUME, TX_SENT_STOP, RX_GOT_RESUME, RX_GOT_STOP;
  logic SER_TX, IR_TX, RTS_N, DTR_N, MEM_CLK, MEM_SEL, MEM_DATA;
  logic [5:0] AVS_ADDRESS, kind;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, q;
  logic [3:0] MODEM_IN, FLOW_SELECT;
  logic [7:0] LINE_STATUS_IN, STOP_CHAR_FIRST, STOP_CHAR_SECOND, RESUME_CHAR_FIRST;
  logic [7:0] RESUME_CHAR_SECOND, DIVISOR, DIVISOR_HIGH, DIVISOR_FRAC;
  logic [6:0] reps;
  int n_fail, n_checks;
  logic [13:0] rows [18] = '{{6'h00, 8'h00}, {6'h01, 8'h00}, {6'h02, 8'h00}, {6'h03, 8'h00},
    {6'h04, 8'h00}, {6'h05, 8'h00}, {6'h06, 8'h00}, {6'h07, 8'h00}, {6'h08, 8'h00},
    {6'h09, 8'h00}, {6'h0A, 8'h60}, {6'h0B, 8'h01}, {6'h0C, 8'hFF}, {6'h0D, 8'h01},
    {6'h0E, 8'h00}, {6'h0F, 8'h00}, {6'h10, 8'hA0}, {6'h3F, 8'h00}};
  urx_block urx_block_inst (.*);
  urx_peer urx_peer_inst (.CLK(CLK), .rst_n(RSTN), .start(start), .kind(kind), .reps(reps),
    .ev({RX_PUSH, RX_POP, TX_SENT_RESUME, TX_SENT_STOP, RX_GOT_RESUME, RX_GOT_STOP}),
    .busy(busy));
  task automatic close_out();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    int i;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= {24'h0, d};
    AVS_WRITE <= w;
    AVS_READ <= !w;
    for (i = 0; i < 20; i++) begin
      @(posedge CLK);
      if (AVS_WAITREQUEST === 1'b0) break;
    end
    if (i == 20) begin
      n_fail++;
      close_out();
    end else begin
      q = AVS_READDATA;
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
      @(posedge CLK);
    end
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, {24'h0, e});
  endtask
  task automatic fire(input logic [5:0] k, input logic [6:0] n);
    int i;
    kind <= k;
    reps <= n;
    start <= 1'b1;
    @(posedge CLK);
    start <= 1'b0;
    for (i = 0; i < 200; i++) begin
      @(posedge CLK);
      if (busy === 1'b0) break;
    end
    if (i == 200) begin
      n_fail++;
      close_out();
    end
  endtask
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  initial begin
    RSTN = 1'b0;
    {AVS_READ, AVS_WRITE, start, kind, reps, AVS_ADDRESS, AVS_WRITEDATA} = '0;
    MODEM_IN = 4'hA;
    LINE_STATUS_IN = 8'h60;
    n_fail = 0;
    n_checks = 0;
    repeat (12) @(posedge CLK);
    RSTN <= 1'b1;
    repeat (3) @(posedge CLK);
    for (int r = 0; r < 18; r++) begin
      rdchk(rows[r][13:8], rows[r][7:0]);
    end
    chk({25'h0, SER_TX, RTS_N, DTR_N, IR_TX, MEM_CLK, MEM_SEL, MEM_DATA}, 32'h70);
    chk({8'h00, DIVISOR, DIVISOR_HIGH, DIVISOR_FRAC}, 32'h010000);
    for (int j = 0; j < 4; j++) begin
      bus(1'b1, 6'(2 + j), 8'(8'h11 + 2 * j));
    end
    chk({STOP_CHAR_FIRST, STOP_CHAR_SECOND, RESUME_CHAR_FIRST, RESUME_CHAR_SECOND}, 32'h11131517);
    bus(1'b1, 6'h01, 8'h03);
    bus(1'b1, 6'h09, 8'h01);
    fire(6'h20, 7'h02);
    chk({31'h0, IRQ}, 32'h0);
    fire(6'h20, 7'h01);
    chk({31'h0, IRQ}, 32'h1);
    rdchk(6'h0B, 8'h00);
    rdchk(6'h00, 8'h03);
    bus(1'b1, 6'h00, 8'h09);
    rdchk(6'h00, 8'h03);
    bus(1'b1, 6'h08, 8'h01);
    chk({31'h0, IRQ}, 32'h0);
    fire(6'h30, 7'h04);
    rdchk(6'h00, 8'h03);
    fire(6'h10, 7'h01);
    rdchk(6'h00, 8'h02);
    fire(6'h20, 7'h01);
    chk({31'h0, IRQ}, 32'h1);
    bus(1'b1, 6'h09, 8'h00);
    chk({31'h0, IRQ}, 32'h0);
    fire(6'h20, 7'd70);
    rdchk(6'h00, 8'h40);
    fire(6'h10, 7'd66);
    rdchk(6'h00, 8'h00);
    bus(1'b1, 6'h08, 8'h07);
    bus(1'b1, 6'h01, 8'h40);
    bus(1'b1, 6'h09, 8'h07);
    fire(6'h20, 7'd63);
    chk({31'h0, IRQ}, 32'h0);
    fire(6'h20, 7'h01);
    chk({31'h0, IRQ}, 32'h1);
    bus(1'b1, 6'h08, 8'h07);
    fire(6'h04, 7'h01);
    rdchk(6'h06, 8'h00);
    bus(1'b1, 6'h07, 8'h0A);
    fire(6'h04, 7'h01);
    fire(6'h08, 7'h01);
    fire(6'h01, 7'h01);
    rdchk(6'h06, 8'h09);
    rdchk(6'h06, 8'h00);
    fire(6'h08, 7'h01);
    fire(6'h04, 7'h01);
    fire(6'h02, 7'h01);
    rdchk(6'h06, 8'h06);
    rdchk(6'h08, 8'h06);
    fire(6'h01, 7'h01);
    bus(1'b1, 6'h07, 8'h00);
    rdchk(6'h06, 8'h00);
    bus(1'b1, 6'h0C, 8'h5A);
    rdchk(6'h0C, 8'h5A);
    MODEM_IN <= 4'h5;
    repeat (5) @(posedge CLK);
    rdchk(6'h10, 8'h5F);
    rdchk(6'h10, 8'h50);
    RSTN <= 1'b0;
    repeat (2) @(posedge CLK);
    RSTN <= 1'b1;
    repeat (3) @(posedge CLK);
    rdchk(6'h0C, 8'hFF);
    rdchk(6'h00, 8'h00);
    rdchk(6'h10, 8'h50);
    chk({STOP_CHAR_FIRST, STOP_CHAR_SECOND, RESUME_CHAR_FIRST, RESUME_CHAR_SECOND}, 32'h0);
    close_out();
  end
endmodule
